// ==== pwm_fault_pkg.sv ====
`default_nettype none

package pwm_fault_pkg;

    // ------------------------------------------------------------------
    // Clock and oscillator
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_65K_HZ = 65_000;
    localparam int OSC_100K_HZ = 100_000;
    localparam int PERIOD_65K_CYC = CLK_HZ / OSC_65K_HZ;
    localparam int PERIOD_100K_CYC = CLK_HZ / OSC_100K_HZ;

    // Least times round up to whole cycles.
    function automatic int ns_to_cyc_up(input int ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction : ns_to_cyc_up

    // ------------------------------------------------------------------
    // Switching cycle timing
    // ------------------------------------------------------------------
    localparam int BLANK_NS = 250;
    localparam int BLANK_CYC = ns_to_cyc_up(BLANK_NS);
    localparam int MAX_ON_65K_NS = 12_300;
    localparam int MAX_ON_100K_NS = 8_000;
    localparam int MAX_ON_65K_CYC = MAX_ON_65K_NS / CLK_PERIOD_NS;
    localparam int MAX_ON_100K_CYC = MAX_ON_100K_NS / CLK_PERIOD_NS;
    localparam int SS_STEPS = 15;
    localparam int SOFT_START_CYC_DEF = 1_000_000;
    localparam int WS_TRIPS = 4;
    localparam int LINE_QUIET_SAMPLES = 2;

    // ------------------------------------------------------------------
    // Protection timers
    // ------------------------------------------------------------------
    localparam int EXT_FAULT_65K_NS = 55_000;
    localparam int EXT_FAULT_100K_NS = 35_000;
    localparam int EXT_FAULT_65K_CYC = ns_to_cyc_up(EXT_FAULT_65K_NS);
    localparam int EXT_FAULT_100K_CYC = ns_to_cyc_up(EXT_FAULT_100K_NS);
    localparam int SUPPLY_FAULT_NS = 10_000;
    localparam int SUPPLY_FAULT_CYC = ns_to_cyc_up(SUPPLY_FAULT_NS);
    localparam int TSD_NS = 10_000;
    localparam int TSD_CYC = ns_to_cyc_up(TSD_NS);
    localparam int OFF_MODE_MS = 150;
    localparam int OFF_MODE_CYC_DEF = OFF_MODE_MS * (CLK_HZ / 1000);
    localparam int FAULT_CYC_DEF = 20_000_000;
    localparam int AUTOREC_CYC_DEF = 100_000_000;

    // ------------------------------------------------------------------
    // Widths and types
    // ------------------------------------------------------------------
    localparam int CYC_W = 11;
    localparam int TMR_W = 27;
    localparam int SS_W = 4;
    localparam int PEAK_W = 3;
    localparam int WS_W = 3;
    localparam int QUIET_W = 2;

    typedef logic [TMR_W-1:0] timer_t;
    typedef logic [CYC_W-1:0] cyc_t;

    typedef enum logic [2:0] {
        ST_WAIT = 3'h0,
        ST_SOFT = 3'h1,
        ST_RUN = 3'h2,
        ST_LATCH = 3'h3,
        ST_AUTOREC = 3'h4,
        ST_STOP = 3'h5,
        ST_TSD = 3'h6,
        ST_OFF = 3'h7
    } prot_state_t;

    // Comparator and detector levels from the analog side.
    typedef struct packed {
        logic pwm_trip;
        logic ilim_trip;
        logic ss_trip;
        logic short_trip;
        logic at_limit;
        logic fb_opce;
        logic fb_below_off;
        logic fb_above_on;
        logic vcc_above_on;
        logic vcc_below_off;
        logic vcc_below_reset;
        logic vcc_over;
        logic line_above_start;
        logic brown_out;
        logic ext_fault;
        logic thermal_shutdown;
        logic hv_cmp;
        logic line_sample;
    } cmp_t;

endpackage : pwm_fault_pkg

`default_nettype wire

// ==== sync_bits.sv ====
`default_nettype none

module sync_bits #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // The first stage feeds only the second stage.
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;

endmodule : sync_bits

`default_nettype wire

// ==== current_mode_pwm_fault_logic.sv ====
// Contract
// - Ignore current sense for 250 ns blanking
// - Feedback setpoint comparator ends the on period
// - Current limit comparator also ends on period
// - Soft-start raises setpoint in 15 steps
// - Soft-start and feedback comparators are OR'ed
// - Four consecutive winding-short trips enter protection
// - Sawtooth reset every oscillator cycle
// - Overpower current only above enable level
// - Sample then reset line-peak code periodically
// - Peak valid after two quiet sample clocks
// - Fault timer at limit; timeout stops switching
// - Fault timer clears when setpoint leaves limit
// - Maximum on-time termination starts fault timer
// - Autorecovery retries after delay, new burst
// - Latch released by brown-out or supply reset
// - External fault persisting 55/35 us latches
// - Low supply for 10 us enters protection
// - Thermal shutdown from wait, stop, soft or run stops switching and startup source
// - Feedback low 150 ms enters off mode
// - Off entry below 0.6 V, restart above 2.2 V
// - On period capped at maximum on-time
`default_nettype none

module current_mode_pwm_fault_logic
    import pwm_fault_pkg::*;
#(
    parameter int SOFT_START_CYC = SOFT_START_CYC_DEF,
    parameter int FAULT_CYC = FAULT_CYC_DEF,
    parameter int AUTOREC_CYC = AUTOREC_CYC_DEF,
    parameter int EXT_FAULT_CYC = EXT_FAULT_65K_CYC,
    parameter int OFF_MODE_CYC = OFF_MODE_CYC_DEF
) (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic freq_100k_in,
    input wire logic autorecovery_in,
    input wire cmp_t comparators_in,
    input wire logic [PEAK_W-1:0] line_peak_code_in,
    output logic gate_drive_output_out,
    output logic sawtooth_reset_out,
    output logic [SS_W-1:0] soft_start_level_out,
    output logic overpower_comp_enable_out,
    output logic peak_detector_reset_out,
    output logic [PEAK_W-1:0] line_peak_out,
    output logic line_peak_valid_out,
    output logic startup_source_enable_out,
    output logic internal_supply_enable_out,
    output prot_state_t protection_state_out
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Saturating persistence counter: counts while the condition holds.
    function automatic timer_t persist(input timer_t cnt, input logic cond);
        if (!cond) begin
            return '0;
        end
        if (&cnt) begin
            return cnt;
        end
        return cnt + timer_t'(1);
    endfunction : persist

    localparam timer_t SS_STEP_CYC = timer_t'(SOFT_START_CYC / SS_STEPS);
    localparam cyc_t BLANK_LIM = cyc_t'(BLANK_CYC);
    localparam logic [SS_W-1:0] SS_FULL = SS_W'(SS_STEPS);
    localparam logic [WS_W-1:0] WS_LIM = WS_W'(WS_TRIPS);
    localparam logic [QUIET_W-1:0] QUIET_LIM = QUIET_W'(LINE_QUIET_SAMPLES);

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic [$bits(cmp_t)-1:0] cmp_bits;
    cmp_t c;

    sync_bits #(
        .WIDTH($bits(cmp_t))
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .async_in(comparators_in),
        .sync_out(cmp_bits)
    );

    assign c = cmp_t'(cmp_bits);

    // ------------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------------
    prot_state_t state_reg;
    prot_state_t state_next;
    cyc_t cyc_reg;
    cyc_t on_cnt_reg;
    logic gate_reg;
    logic saw_reg;
    logic [SS_W-1:0] level_reg;
    timer_t ss_div_reg;
    logic short_seen_reg;
    logic [WS_W-1:0] ws_cnt_reg;
    logic fault_hold_reg;
    timer_t fault_tmr_reg;
    timer_t low_tmr_reg;
    timer_t over_tmr_reg;
    timer_t ext_tmr_reg;
    timer_t tsd_tmr_reg;
    timer_t off_tmr_reg;
    timer_t ar_tmr_reg;
    logic opc_reg;
    logic hv_prev_reg;
    logic samp_prev_reg;
    logic armed_reg;
    logic [QUIET_W-1:0] quiet_reg;
    logic [PEAK_W-1:0] peak_reg;
    logic peak_valid_reg;
    logic peak_rst_reg;

    // ------------------------------------------------------------------
    // Switching cycle decode
    // ------------------------------------------------------------------
    wire switching = (state_reg == ST_SOFT) || (state_reg == ST_RUN);
    wire in_soft = (state_reg == ST_SOFT);
    wire cyc_t period_lim = freq_100k_in ? cyc_t'(PERIOD_100K_CYC - 1)
                                         : cyc_t'(PERIOD_65K_CYC - 1);
    wire cyc_t max_on_lim = freq_100k_in ? cyc_t'(MAX_ON_100K_CYC - 1)
                                         : cyc_t'(MAX_ON_65K_CYC - 1);
    wire cycle_start = switching && (cyc_reg == '0);
    wire blank = on_cnt_reg < BLANK_LIM;
    wire sense_ok = gate_reg && !blank;
    wire term_cmp = sense_ok && (c.pwm_trip || c.ilim_trip
                    || (in_soft && c.ss_trip));
    wire term_max = gate_reg && (on_cnt_reg == max_on_lim);
    wire ss_tick = in_soft && (ss_div_reg >= SS_STEP_CYC - timer_t'(1));

    // ------------------------------------------------------------------
    // Protection event decode
    // ------------------------------------------------------------------
    wire timer_t ext_lim = freq_100k_in ? timer_t'(EXT_FAULT_100K_CYC)
                                        : timer_t'(EXT_FAULT_CYC);
    wire fault_run = switching && (c.at_limit || fault_hold_reg);
    wire fault_to = fault_tmr_reg >= timer_t'(FAULT_CYC);
    wire ws_event = ws_cnt_reg >= WS_LIM;
    wire low_to = low_tmr_reg >= timer_t'(SUPPLY_FAULT_CYC);
    wire over_to = over_tmr_reg >= timer_t'(SUPPLY_FAULT_CYC);
    wire ext_to = ext_tmr_reg >= ext_lim;
    wire tsd_to = tsd_tmr_reg >= timer_t'(TSD_CYC);
    wire off_to = off_tmr_reg >= timer_t'(OFF_MODE_CYC);
    wire ar_to = ar_tmr_reg >= timer_t'(AUTOREC_CYC);
    wire start_ok = c.line_above_start && c.vcc_above_on;
    wire latch_release = c.brown_out || c.vcc_below_reset;
    wire retry_fault = fault_to || ws_event || low_to;
    wire prot_state_t fault_dest = autorecovery_in ? ST_AUTOREC : ST_LATCH;

    // ------------------------------------------------------------------
    // Protection state machine
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_WAIT, ST_STOP: begin
                if (tsd_to) begin
                    state_next = ST_TSD;
                end else if (start_ok && !c.brown_out) begin
                    state_next = ST_SOFT;
                end
            end
            ST_SOFT, ST_RUN: begin
                if (c.brown_out) begin
                    state_next = ST_STOP;
                end else if (tsd_to) begin
                    state_next = ST_TSD;
                end else if (ext_to || over_to) begin
                    state_next = ST_LATCH;
                end else if (retry_fault) begin
                    state_next = fault_dest;
                end else if (off_to) begin
                    state_next = ST_OFF;
                end else if (in_soft && level_reg == SS_FULL) begin
                    state_next = ST_RUN;
                end
            end
            ST_LATCH: begin
                if (c.vcc_below_reset) begin
                    state_next = ST_WAIT;
                end else if (c.brown_out) begin
                    state_next = ST_STOP;
                end
            end
            ST_AUTOREC: begin
                if (latch_release || ar_to) begin
                    state_next = ST_WAIT;
                end
            end
            ST_TSD: begin
                if (start_ok && !c.thermal_shutdown) begin
                    state_next = ST_SOFT;
                end
            end
            ST_OFF: begin
                if (start_ok && c.fb_above_on) begin
                    state_next = ST_SOFT;
                end
            end
            default: begin
                state_next = ST_WAIT;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            state_reg <= ST_WAIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Oscillator, gate drive and sawtooth
    // ------------------------------------------------------------------
    // Comparator paths carry two cycles of synchroniser delay, so the
    // gate turns off three clocks after the analog trip.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || !switching) begin
            cyc_reg <= '0;
            gate_reg <= 1'b0;
            on_cnt_reg <= '0;
            saw_reg <= 1'b0;
        end else begin
            cyc_reg <= (cyc_reg >= period_lim) ? '0 : cyc_reg + cyc_t'(1);
            on_cnt_reg <= gate_reg ? on_cnt_reg + cyc_t'(1) : '0;
            saw_reg <= cycle_start;
            if (cycle_start) begin
                gate_reg <= 1'b1;
            end else if (term_cmp || term_max) begin
                gate_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Soft-start staircase
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || !switching) begin
            level_reg <= '0;
            ss_div_reg <= '0;
        end else if (!in_soft) begin
            level_reg <= SS_FULL;
            ss_div_reg <= '0;
        end else if (ss_tick) begin
            ss_div_reg <= '0;
            if (level_reg != SS_FULL) begin
                level_reg <= level_reg + SS_W'(1);
            end
        end else begin
            ss_div_reg <= ss_div_reg + timer_t'(1);
        end
    end

    // ------------------------------------------------------------------
    // Winding short and fault timer
    // ------------------------------------------------------------------
    // A cycle only counts as a trip if the short comparator fired after
    // blanking; any clean cycle restarts the count of four.
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || !switching) begin
            short_seen_reg <= 1'b0;
            ws_cnt_reg <= '0;
            fault_hold_reg <= 1'b0;
        end else begin
            if (cycle_start) begin
                short_seen_reg <= 1'b0;
                if (!short_seen_reg) begin
                    ws_cnt_reg <= '0;
                end else if (ws_cnt_reg != WS_LIM) begin
                    ws_cnt_reg <= ws_cnt_reg + WS_W'(1);
                end
            end else if (sense_ok && c.short_trip) begin
                short_seen_reg <= 1'b1;
            end
            if (term_max) begin
                fault_hold_reg <= 1'b1;
            end else if (term_cmp) begin
                fault_hold_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Protection timers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            fault_tmr_reg <= '0;
            low_tmr_reg <= '0;
            over_tmr_reg <= '0;
            ext_tmr_reg <= '0;
            tsd_tmr_reg <= '0;
            off_tmr_reg <= '0;
            ar_tmr_reg <= '0;
        end else begin
            fault_tmr_reg <= persist(fault_tmr_reg, fault_run);
            low_tmr_reg <= persist(low_tmr_reg, switching && c.vcc_below_off);
            over_tmr_reg <= persist(over_tmr_reg, switching && c.vcc_over);
            ext_tmr_reg <= persist(ext_tmr_reg, switching && c.ext_fault);
            tsd_tmr_reg <= persist(tsd_tmr_reg, c.thermal_shutdown && state_reg != ST_TSD);
            off_tmr_reg <= persist(off_tmr_reg, switching && c.fb_below_off);
            ar_tmr_reg <= persist(ar_tmr_reg, state_reg == ST_AUTOREC);
        end
    end

    // ------------------------------------------------------------------
    // Overpower compensation and line peak validation
    // ------------------------------------------------------------------
    // A peak is trusted only once the HV comparator has stayed silent for
    // two sample events after a falling edge; a rising edge disarms it.
    wire hv_edge = c.hv_cmp ^ hv_prev_reg;
    wire hv_fall = hv_prev_reg && !c.hv_cmp;
    wire samp_ev = c.line_sample && !samp_prev_reg;
    wire quiet_step = samp_ev && armed_reg && !hv_edge && (quiet_reg != QUIET_LIM);
    wire commit = quiet_step && (quiet_reg == QUIET_LIM - QUIET_W'(1));

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            opc_reg <= 1'b0;
            hv_prev_reg <= 1'b0;
            samp_prev_reg <= 1'b0;
            armed_reg <= 1'b0;
            quiet_reg <= '0;
            peak_reg <= '0;
            peak_valid_reg <= 1'b0;
            peak_rst_reg <= 1'b0;
        end else begin
            opc_reg <= switching && c.fb_opce;
            hv_prev_reg <= c.hv_cmp;
            samp_prev_reg <= c.line_sample;
            peak_rst_reg <= samp_ev;
            if (hv_edge) begin
                armed_reg <= hv_fall;
                quiet_reg <= '0;
            end else if (quiet_step) begin
                quiet_reg <= quiet_reg + QUIET_W'(1);
            end
            if (commit) begin
                peak_reg <= line_peak_code_in;
                peak_valid_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign gate_drive_output_out = gate_reg;
    assign sawtooth_reset_out = saw_reg;
    assign soft_start_level_out = level_reg;
    assign overpower_comp_enable_out = opc_reg;
    assign peak_detector_reset_out = peak_rst_reg;
    assign line_peak_out = peak_reg;
    assign line_peak_valid_out = peak_valid_reg;
    assign startup_source_enable_out = (state_reg != ST_TSD);
    assign internal_supply_enable_out = (state_reg != ST_OFF);
    assign protection_state_out = state_reg;

endmodule : current_mode_pwm_fault_logic

`default_nettype wire

// ==== pwm_fault_pkg_unused_guard.sv ====
`default_nettype none
`default_nettype wire

// ==== switch_sense_model.sv ====
`default_nettype none
module switch_sense_model
    import pwm_fault_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic gate_in,
    input wire logic [SS_W-1:0] level_in,
    input wire logic [11:0] sp_in,
    input wire logic [11:0] lim_in,
    input wire logic short_in,
    output logic pwm_out,
    output logic ilim_out,
    output logic ss_out,
    output logic short_out
);
    // Each pulse starts from zero current.
    logic [11:0] ramp_reg;
    always_ff @(posedge ref_clk_in) begin
        ramp_reg <= gate_in ? ramp_reg + 12'h001 : 12'h000;
    end
    assign pwm_out = gate_in && ramp_reg >= sp_in;
    assign ilim_out = gate_in && ramp_reg >= lim_in;
    assign ss_out = gate_in && ramp_reg >= {5'h0, level_in, 3'h0};
    assign short_out = short_in && pwm_out;
endmodule : switch_sense_model
`default_nettype wire

// ==== current_mode_pwm_fault_logic_asserts.sv ====
`default_nettype none
module pwm_fault_asserts
    import pwm_fault_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic freq_100k_in,
    input wire logic gate_drive_output_out,
    input wire logic sawtooth_reset_out,
    input wire logic [SS_W-1:0] soft_start_level_out,
    input wire logic overpower_comp_enable_out,
    input wire logic peak_detector_reset_out,
    input wire logic line_peak_valid_out,
    input wire logic startup_source_enable_out,
    input wire logic internal_supply_enable_out,
    input wire prot_state_t protection_state_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);
    // Holds the length of a gate pulse for the one cycle after it ends.
    logic [11:0] hi_reg;
    wire logic sw = protection_state_out inside {ST_SOFT, ST_RUN};
    wire logic gt = gate_drive_output_out;
    wire prot_state_t ps = protection_state_out;
    always_ff @(posedge ref_clk_in) begin
        hi_reg <= (reset_in || !gt) ? 12'h000 : hi_reg + 12'h001;
    end
    sequence s_rise;
        $rose(gt);
    endsequence
    sequence s_saw;
        sawtooth_reset_out ##1 !sawtooth_reset_out;
    endsequence
    AST_SAW: assert property (s_rise |-> s_saw) else $error("no ramp reset");
    AST_BLANK: assert property ($fell(gt) && sw |-> hi_reg >= 12'h019)
        else $error("pulse cut in blanking");
    AST_MAXON: assert property ($fell(gt) |-> hi_reg <= (freq_100k_in ? 12'h320 : 12'h4ce))
        else $error("pulse too long");
    AST_STOP: assert property (!sw ##1 !sw |-> !gt && soft_start_level_out == 4'h0)
        else $error("gate on while stopped");
    AST_RUN: assert property (ps == ST_RUN |-> soft_start_level_out == 4'hf)
        else $error("run below full level");
    AST_STEP: assert property (sw && $past(sw) && $changed(soft_start_level_out) |->
        soft_start_level_out == $past(soft_start_level_out) + 4'h1) else $error("bad step");
    AST_OPC: assert property (overpower_comp_enable_out |-> sw || $past(sw))
        else $error("overpower current while idle");
    AST_TSD: assert property (startup_source_enable_out != (ps == ST_TSD))
        else $error("startup source wrong");
    AST_OFF: assert property (internal_supply_enable_out != (ps == ST_OFF))
        else $error("internal supply wrong");
    AST_PDR: assert property (peak_detector_reset_out |=> !peak_detector_reset_out)
        else $error("peak reset too long");
    AST_VAL: assert property (line_peak_valid_out |=> line_peak_valid_out)
        else $error("valid dropped");
endmodule : pwm_fault_asserts
bind current_mode_pwm_fault_logic pwm_fault_asserts u_chk (
    .ref_clk_in, .reset_in, .freq_100k_in, .gate_drive_output_out, .sawtooth_reset_out,
    .soft_start_level_out, .overpower_comp_enable_out, .peak_detector_reset_out,
    .line_peak_valid_out, .startup_source_enable_out, .internal_supply_enable_out,
    .protection_state_out
);
`default_nettype wire

// ==== current_mode_pwm_fault_logic_tb.sv ====
`default_nettype none
module current_mode_pwm_fault_logic_tb
    import pwm_fault_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic f = 1'h0;
    logic rst = 1'h1;
    logic arec = 1'h0;
    logic sh = 1'h0;
    logic [PEAK_W-1:0] code = 3'h0;
    logic [11:0] sp = 12'hfff;
    logic [11:0] lim = 12'hfff;
    cmp_t c = '0;
    cmp_t cin;
    logic gate, opce, pdr, valid, st_en, is_en, pw, il, ss, ws;
    logic [SS_W-1:0] lvl;
    logic [PEAK_W-1:0] peak;
    prot_state_t st;
    prot_state_t last = ST_WAIT;
    prot_state_t q[$];
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    always_comb begin
        cin = c;
        cin.pwm_trip = pw;
        cin.ilim_trip = il;
        cin.ss_trip = ss;
        cin.short_trip = ws;
    end
    current_mode_pwm_fault_logic #(.SOFT_START_CYC(150), .FAULT_CYC(200), .AUTOREC_CYC(100),
        .EXT_FAULT_CYC(50), .OFF_MODE_CYC(100)) dut (
        .ref_clk_in(clk), .reset_in(rst), .freq_100k_in(f), .autorecovery_in(arec),
        .comparators_in(cin), .line_peak_code_in(code), .gate_drive_output_out(gate),
        .sawtooth_reset_out(), .soft_start_level_out(lvl), .overpower_comp_enable_out(opce),
        .peak_detector_reset_out(pdr), .line_peak_out(peak), .line_peak_valid_out(valid),
        .startup_source_enable_out(st_en), .internal_supply_enable_out(is_en),
        .protection_state_out(st));
    switch_sense_model sw_model (.ref_clk_in(clk), .gate_in(gate), .level_in(lvl), .sp_in(sp),
        .lim_in(lim), .short_in(sh), .pwm_out(pw), .ilim_out(il), .ss_out(ss), .short_out(ws));
    task automatic wrap_up();
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (e !== s) begin
            num_errors++;
            $display("unexpected %s expected %0h seen %0h", n, e, s);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic go(input prot_state_t s);
        q.push_back(s);
        for (int i = 0; i < 20000 && st !== s; i++) tick(1);
        chk("state_reached", s, st);
    endtask : go
    task automatic up();
        go(ST_SOFT);
        go(ST_RUN);
    endtask : up
    // The cycle ceiling bounds these waits.
    task automatic width(output int w);
        w = 0;
        while (gate !== 1'h1) tick(1);
        while (gate === 1'h1) begin
            w++;
            tick(1);
        end
    endtask : width
    task automatic samp();
        c.line_sample = 1'h1;
        tick(4);
        c.line_sample = 1'h0;
        tick(4);
    endtask : samp
    // Each state change takes the oldest note.
    always @(negedge clk) begin
        if (!rst && st !== last) begin
            if (q.size() == 0) begin
                num_errors++;
                $display("unexpected state expected none seen %0h", st);
            end else chk("state", q.pop_front(), st);
        end
        last = st;
        cyc++;
        if (cyc > 60000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        int w;
        w = $urandom(32'h6f18);
        tick(5);
        rst = 1'h0;
        chk("reset_outputs", 3'h6, {st_en, is_en, gate});
        c.line_above_start = 1'h1;
        c.vcc_above_on = 1'h1;
        go(ST_SOFT);
        width(w);
        chk("soft_pulse", 1'h1, w >= 25 && w <= 30);
        go(ST_RUN);
        sp = 12'h12c + 12'($urandom_range(79));
        width(w);
        width(w);
        chk("fb_pulse", 1'h1, w > sp && w <= sp + 4);
        lim = 12'h0c8;
        width(w);
        width(w);
        chk("ilim_pulse", 1'h1, w > 200 && w <= 204);
        c.fb_opce = 1'h1;
        tick(4);
        chk("opce_on", 1'h1, opce);
        c.fb_opce = 1'h0;
        tick(4);
        chk("opce_off", 1'h0, opce);
        c.at_limit = 1'h1;
        tick(150);
        c.at_limit = 1'h0;
        tick(300);
        chk("fault_cleared", ST_RUN, st);
        arec = 1'h1;
        c.at_limit = 1'h1;
        go(ST_AUTOREC);
        c.at_limit = 1'h0;
        go(ST_WAIT);
        up();
        arec = 1'h0;
        width(w);
        sp = 12'hfff;
        lim = 12'hfff;
        width(w);
        chk("max_on", 1230, w);
        go(ST_LATCH);
        sp = 12'h12c;
        tick(300);
        chk("latch_hold", ST_LATCH, st);
        c.vcc_above_on = 1'h0;
        c.vcc_below_reset = 1'h1;
        go(ST_WAIT);
        c.vcc_below_reset = 1'h0;
        c.vcc_above_on = 1'h1;
        up();
        c.ext_fault = 1'h1;
        tick(30);
        c.ext_fault = 1'h0;
        tick(10);
        f = 1'h1;
        c.ext_fault = 1'h1;
        tick(3400);
        chk("ext_100k", ST_RUN, st);
        go(ST_LATCH);
        c.ext_fault = 1'h0;
        c.brown_out = 1'h1;
        go(ST_STOP);
        c.brown_out = 1'h0;
        up();
        c.vcc_over = 1'h1;
        go(ST_LATCH);
        c.vcc_over = 1'h0;
        c.brown_out = 1'h1;
        go(ST_STOP);
        c.brown_out = 1'h0;
        up();
        arec = 1'h1;
        sh = 1'h1;
        go(ST_AUTOREC);
        sh = 1'h0;
        go(ST_WAIT);
        up();
        c.thermal_shutdown = 1'h1;
        go(ST_TSD);
        c.thermal_shutdown = 1'h0;
        up();
        c.fb_below_off = 1'h1;
        go(ST_OFF);
        c.fb_below_off = 1'h0;
        tick(50);
        chk("off_hold", ST_OFF, st);
        c.fb_above_on = 1'h1;
        up();
        c.fb_above_on = 1'h0;
        c.hv_cmp = 1'h1;
        tick(4);
        c.hv_cmp = 1'h0;
        tick(4);
        samp();
        chk("peak_early", 1'h0, valid);
        code = 3'($urandom);
        samp();
        chk("peak_code", {1'h1, code}, {valid, peak});
        arec = 1'h0;
        c.vcc_below_off = 1'h1;
        go(ST_LATCH);
        wrap_up();
    end
endmodule : current_mode_pwm_fault_logic_tb
`default_nettype wire
